// ==== port_dir_pkg.sv ====
// Constants for the port direction block: register indices, byte
// addresses, widths and reset values.
// Assumes a 32-bit AHB-Lite slave port decoding the low 12 address bits.
// Behaviour
// RL1: A direction bit of 0 makes its pin an input and a bit of 1 makes it an output.
// RL2: The port 5 direction register sits at index e8, holds eight write-only bits and resets to 0.
// RL3: The port 6 direction register sits at index e9, holds eight write-only bits and resets to 0.
// RL4: The port 7 direction register sits at index ea, holds eight write-only bits and resets to 0.
// RL5: The port 8 direction register holds eight write-only bits that reset to 0.
// RL6: The port A direction register has readable and writable bits 3 to 0 reset to 0, bits 7 to 4 unused and 0.
// RL7: Reading a write-only direction register returns a fixed value, not the stored bits.
package port_dir_pkg;
  localparam int          REG_W        = 8;
  localparam int          PORTA_W      = 4;
  localparam int          IDX_W        = 10;
  localparam logic [7:0]  IDX_PORT5    = 8'he8;
  localparam logic [7:0]  IDX_PORT6    = 8'he9;
  localparam logic [7:0]  IDX_PORT7    = 8'hea;
  localparam logic [7:0]  IDX_PORT8    = 8'heb;
  localparam logic [7:0]  IDX_PORTA    = 8'hec;
  localparam logic [11:0] ADDR_PORT5   = {2'h0, IDX_PORT5, 2'h0};
  localparam logic [11:0] ADDR_PORT6   = {2'h0, IDX_PORT6, 2'h0};
  localparam logic [11:0] ADDR_PORT7   = {2'h0, IDX_PORT7, 2'h0};
  localparam logic [11:0] ADDR_PORT8   = {2'h0, IDX_PORT8, 2'h0};
  localparam logic [11:0] ADDR_PORTA   = {2'h0, IDX_PORTA, 2'h0};
  localparam logic [7:0]  RST_DIR      = 8'h00;
  localparam logic [31:0] WO_READ_VAL  = 32'h0000_0000;
  localparam logic [1:0]  HTRANS_IDLE  = 2'h0;
  localparam logic [1:0]  HTRANS_NSEQ  = 2'h2;
endpackage

// ==== dir_reg.sv ====
// One direction register, one flip-flop per pin.
// Assumes a synchronous reset copy already released on mclk.
`timescale 1ns/10ps
module dir_reg #(
  parameter int WIDTH = 8
) (
  input  wire logic             mclk,
  input  wire logic             rstSyncN,
  input  wire logic             wrEn,
  input  wire logic [WIDTH-1:0] wrData,
  output logic      [WIDTH-1:0] q
);
  // Wider registers would need more than the low data byte lane
  if (WIDTH < 1 || WIDTH > 8)
  begin : g_bad_width
    $error("dir_reg WIDTH must be 1 to 8");
  end

  genvar b;
  generate
    for (b = 0; b < WIDTH; b++)
    begin : g_bit
      always_ff @(posedge mclk or negedge rstSyncN)
      begin
        if (!rstSyncN)
          q[b] <= 1'b0;
        else if (wrEn)
          q[b] <= wrData[b];
      end
    end
  endgenerate
endmodule

// ==== port_direction_control.sv ====
// Direction control for ports 5, 6, 7, 8 and A behind an AHB-Lite slave.
// Assumes one slave per bus: hreadyout is the bus hready; zero wait states.
//
// Local design decision: register access over AHB-Lite.
`timescale 1ns/10ps
module port_direction_control (
  input  wire logic                               mclk,
  input  wire logic                               rst_n,
  input  wire logic                               hsel,
  input  wire logic [31:0]                        haddr,
  input  wire logic [1:0]                         htrans,
  input  wire logic                               hwrite,
  input  wire logic [2:0]                         hsize,
  input  wire logic [31:0]                        hwdata,
  input  wire logic                               hready,
  output logic      [31:0]                        hrdata,
  output logic                                    hreadyout,
  output logic                                    hresp,
  output logic      [port_dir_pkg::REG_W-1:0]     port5Oe,
  output logic      [port_dir_pkg::REG_W-1:0]     port6Oe,
  output logic      [port_dir_pkg::REG_W-1:0]     port7Oe,
  output logic      [port_dir_pkg::REG_W-1:0]     port8Oe,
  output logic      [port_dir_pkg::PORTA_W-1:0]   portaOe
);
  logic                                 rstMeta;
  logic                                 rstSyncN;
  logic                                 wrPend;
  logic [4:0]                           wrSel;
  logic                                 rdPend;
  logic                                 rdSelA;
  logic [port_dir_pkg::REG_W-1:0]       port5Dir;
  logic [port_dir_pkg::REG_W-1:0]       port6Dir;
  logic [port_dir_pkg::REG_W-1:0]       port7Dir;
  logic [port_dir_pkg::REG_W-1:0]       port8Dir;
  logic [port_dir_pkg::PORTA_W-1:0]     portaDir;
  wire                                  addrPhase;
  wire  [11:0]                          addrLow;
  wire                                  hitP5;
  wire                                  hitP6;
  wire                                  hitP7;
  wire                                  hitP8;
  wire                                  hitPA;
  wire  [4:0]                           next_wrSel;
  wire  [port_dir_pkg::PORTA_W-1:0]     portaView;
  wire  [31:0]                          next_hrdata;

  // Reset release through two flops
  always_ff @(posedge mclk or negedge rst_n)
  begin
    if (!rst_n)
    begin
      rstMeta  <= 1'b0;
      rstSyncN <= 1'b0;
    end
    else
    begin
      rstMeta  <= 1'b1;
      rstSyncN <= rstMeta;
    end
  end

  assign addrPhase  = hsel && htrans[1] && hready;
  assign addrLow    = haddr[11:0];
  assign hitP5      = addrLow == port_dir_pkg::ADDR_PORT5; // RL2
  assign hitP6      = addrLow == port_dir_pkg::ADDR_PORT6; // RL3
  assign hitP7      = addrLow == port_dir_pkg::ADDR_PORT7; // RL4
  assign hitP8      = addrLow == port_dir_pkg::ADDR_PORT8; // RL5
  assign hitPA      = addrLow == port_dir_pkg::ADDR_PORTA; // RL6
  assign next_wrSel = {hitPA, hitP8, hitP7, hitP6, hitP5};

  // A read straight after a port A write sees the new value
  assign portaView   = (wrPend && wrSel[4]) ? hwdata[port_dir_pkg::PORTA_W-1:0] : portaDir;
  // Write-only registers and unmapped words read a fixed value
  assign next_hrdata = hitPA
                       ? {{(32 - port_dir_pkg::PORTA_W){1'b0}}, portaView} // RL6
                       : port_dir_pkg::WO_READ_VAL; // RL7

  always_ff @(posedge mclk or negedge rstSyncN)
  begin
    if (!rstSyncN)
    begin
      wrPend    <= 1'b0;
      wrSel     <= 5'h00;
      rdPend    <= 1'b0;
      rdSelA    <= 1'b0;
      hrdata    <= 32'h0000_0000;
      hreadyout <= 1'b1;
      hresp     <= 1'b0;
    end
    else
    begin
      wrPend <= addrPhase && hwrite;
      wrSel  <= (addrPhase && hwrite) ? next_wrSel : 5'h00;
      rdPend <= addrPhase && !hwrite;
      rdSelA <= addrPhase && !hwrite && hitPA;
      if (addrPhase && !hwrite)
        hrdata <= next_hrdata;
    end
  end

  // Pin drivers are enabled exactly by the stored bits
  dir_reg #(.WIDTH(port_dir_pkg::REG_W)) u_port5 (
    .mclk     (mclk),
    .rstSyncN (rstSyncN),
    .wrEn     (wrSel[0]), // RL2
    .wrData   (hwdata[port_dir_pkg::REG_W-1:0]),
    .q        (port5Dir)
  );
  dir_reg #(.WIDTH(port_dir_pkg::REG_W)) u_port6 (
    .mclk     (mclk),
    .rstSyncN (rstSyncN),
    .wrEn     (wrSel[1]), // RL3
    .wrData   (hwdata[port_dir_pkg::REG_W-1:0]),
    .q        (port6Dir)
  );
  dir_reg #(.WIDTH(port_dir_pkg::REG_W)) u_port7 (
    .mclk     (mclk),
    .rstSyncN (rstSyncN),
    .wrEn     (wrSel[2]), // RL4
    .wrData   (hwdata[port_dir_pkg::REG_W-1:0]),
    .q        (port7Dir)
  );
  dir_reg #(.WIDTH(port_dir_pkg::REG_W)) u_port8 (
    .mclk     (mclk),
    .rstSyncN (rstSyncN),
    .wrEn     (wrSel[3]), // RL5
    .wrData   (hwdata[port_dir_pkg::REG_W-1:0]),
    .q        (port8Dir)
  );
  // Upper nibble of port A is not stored at all
  dir_reg #(.WIDTH(port_dir_pkg::PORTA_W)) u_porta (
    .mclk     (mclk),
    .rstSyncN (rstSyncN),
    .wrEn     (wrSel[4]), // RL6
    .wrData   (hwdata[port_dir_pkg::PORTA_W-1:0]),
    .q        (portaDir)
  );

  // Output enable 1 drives the pin, 0 leaves it an input
  assign port5Oe = port5Dir; // RL1
  assign port6Oe = port6Dir; // RL1
  assign port7Oe = port7Dir; // RL1
  assign port8Oe = port8Dir; // RL1
  assign portaOe = portaDir; // RL1

  default clocking cb @(posedge mclk); endclocking
  default disable iff (!rstSyncN);

  property p_rst_inputs;
    $rose(rstSyncN) |-> (port5Oe == 8'h00) && (port6Oe == 8'h00) && (port7Oe == 8'h00)
                        && (port8Oe == 8'h00) && (portaOe == 4'h0);
  endproperty
  a_rst_inputs: assert property (p_rst_inputs) else $error("Pins not inputs after reset"); // RL1

  property p_port5_write;
    addrPhase && hwrite && hitP5 ##1 1'b1 |=> port5Oe == $past(hwdata[7:0]);
  endproperty
  a_port5_write: assert property (p_port5_write) else $error("Port 5 write lost"); // RL2

  property p_port6_write;
    addrPhase && hwrite && hitP6 ##1 1'b1 |=> port6Oe == $past(hwdata[7:0]);
  endproperty
  a_port6_write: assert property (p_port6_write) else $error("Port 6 write lost"); // RL3

  property p_port7_write;
    addrPhase && hwrite && hitP7 ##1 1'b1 |=> port7Oe == $past(hwdata[7:0]);
  endproperty
  a_port7_write: assert property (p_port7_write) else $error("Port 7 write lost"); // RL4

  property p_port8_hold;
    !wrSel[3] |=> $stable(port8Oe);
  endproperty
  a_port8_hold: assert property (p_port8_hold) else $error("Port 8 changed without write"); // RL5

  property p_porta_read;
    addrPhase && !hwrite && hitPA && !(wrPend && wrSel[4])
      |=> hrdata == {28'h0000000, portaOe};
  endproperty
  a_porta_read: assert property (p_porta_read) else $error("Port A readback wrong"); // RL6

  property p_wo_read;
    addrPhase && !hwrite && !hitPA |=> hrdata == 32'h0000_0000;
  endproperty
  a_wo_read: assert property (p_wo_read) else $error("Write-only read not fixed"); // RL7

  property p_okay;
    hreadyout && !hresp;
  endproperty
  a_okay: assert property (p_okay) else $error("Slave not ready or not OKAY"); // RL7

  property p_port8_write;
    addrPhase && hwrite && hitP8 ##1 1'b1 |=> port8Oe == $past(hwdata[7:0]);
  endproperty
  a_port8_write: assert property (p_port8_write) else $error("Port 8 write lost"); // RL5

  // Only the low nibble is kept; the upper data bits must not leak in
  property p_porta_write;
    addrPhase && hwrite && hitPA ##1 1'b1 |=> portaOe == $past(hwdata[3:0]);
  endproperty
  a_porta_write: assert property (p_porta_write) else $error("Port A write lost"); // RL6

  property p_port5_hold;
    !wrSel[0] |=> $stable(port5Oe);
  endproperty
  a_port5_hold: assert property (p_port5_hold) else $error("Port 5 changed without write"); // RL2

  property p_port6_hold;
    !wrSel[1] |=> $stable(port6Oe);
  endproperty
  a_port6_hold: assert property (p_port6_hold) else $error("Port 6 changed without write"); // RL3

  property p_port7_hold;
    !wrSel[2] |=> $stable(port7Oe);
  endproperty
  a_port7_hold: assert property (p_port7_hold) else $error("Port 7 changed without write"); // RL4

  property p_porta_hold;
    !wrSel[4] |=> $stable(portaOe);
  endproperty
  a_porta_hold: assert property (p_porta_hold) else $error("Port A changed without write"); // RL6

  // Two strobes at once would copy one data word into two ports
  property p_one_select;
    $onehot0(wrSel);
  endproperty
  a_one_select: assert property (p_one_select) else $error("More than one register written"); // RL2

  property p_unmapped_write;
    addrPhase && hwrite && !(|next_wrSel) |=> wrSel == 5'h00;
  endproperty
  a_unmapped_write: assert property (p_unmapped_write) else $error("Unmapped write stored"); // RL5

  // A read data phase never disturbs any pin direction
  property p_read_keeps_pins;
    rdPend |=> $stable(port5Oe) && $stable(port6Oe) && $stable(port7Oe)
               && $stable(port8Oe) && $stable(portaOe);
  endproperty
  a_read_keeps_pins: assert property (p_read_keeps_pins) else $error("Read moved a pin"); // RL1

  property p_read_no_strobe;
    rdPend |-> wrSel == 5'h00;
  endproperty
  a_read_no_strobe: assert property (p_read_no_strobe) else $error("Strobe during read"); // RL2

  // Bypass path: software may read port A in the cycle after writing it
  property p_porta_bypass;
    wrPend && wrSel[4] && addrPhase && !hwrite && hitPA
      |=> hrdata == {28'h0000000, $past(hwdata[3:0])};
  endproperty
  a_porta_bypass: assert property (p_porta_bypass) else $error("Port A bypass wrong"); // RL6

  property p_porta_upper;
    rdSelA |-> hrdata[31:4] == 28'h0000000;
  endproperty
  a_porta_upper: assert property (p_porta_upper) else $error("Port A upper bits set"); // RL6

  property p_hrdata_hold;
    !(addrPhase && !hwrite) |=> $stable(hrdata);
  endproperty
  a_hrdata_hold: assert property (p_hrdata_hold) else $error("Read data moved"); // RL7

  property p_rd_ready;
    rdPend |-> hreadyout;
  endproperty
  a_rd_ready: assert property (p_rd_ready) else $error("Read data phase stalled"); // RL7

  property p_rst_bus;
    $rose(rstSyncN) |-> (hrdata == 32'h0000_0000) && hreadyout && !hresp;
  endproperty
  a_rst_bus: assert property (p_rst_bus) else $error("Bus outputs wrong after reset"); // RL7

  property p_rst_strobe;
    $rose(rstSyncN) |-> (wrSel == 5'h00) && !wrPend && !rdPend;
  endproperty
  a_rst_strobe: assert property (p_rst_strobe) else $error("Pending transfer after reset"); // RL2

  property p_wo_read_hides;
    addrPhase && !hwrite && (hitP5 || hitP6 || hitP7 || hitP8) |=> hrdata == 32'h0000_0000;
  endproperty
  a_wo_read_hides: assert property (p_wo_read_hides) else $error("Stored bits readable"); // RL7

  property p_wr_pend_sel;
    wrPend |-> rdSelA == 1'b0;
  endproperty
  a_wr_pend_sel: assert property (p_wr_pend_sel) else $error("Write and read both pending"); // RL6

  property p_idle_no_strobe;
    !addrPhase |=> wrSel == 5'h00;
  endproperty
  a_idle_no_strobe: assert property (p_idle_no_strobe) else $error("Strobe without transfer"); // RL5

  // Main scenarios worth seeing at least once
  c_port5_write: cover property (addrPhase && hwrite && hitP5 ##1 hwdata[7:0] == 8'hff);
  c_port8_write: cover property (wrSel[3] && hwdata[7:0] != 8'h00);
  c_porta_read:  cover property (rdSelA && portaOe != 4'h0);
  c_back_to_back: cover property (wrPend && wrSel[4] && addrPhase && !hwrite && hitPA);
endmodule

// ==== tb_port_direction_control.sv ====
// Self-checking bench for the port direction block over AHB-Lite.
// Assumes a single slave: hreadyout is fed back as the bus hready.
`timescale 1ns/10ps
`define CHK(nm, exp, got) begin totalChecks++; if ((got) !== (exp)) begin nFail++; \
  $display("wrong value %s expected %h seen %h", nm, exp, got); end end
module tb_port_direction_control;
  typedef struct {logic [31:0] rd; logic [35:0] oe;} note_s;
  localparam logic [11:0] REG_ADDR [5] = '{port_dir_pkg::ADDR_PORT5, port_dir_pkg::ADDR_PORT6,
    port_dir_pkg::ADDR_PORT7, port_dir_pkg::ADDR_PORT8, port_dir_pkg::ADDR_PORTA};
  logic        mclk    = 1'b0;
  logic        rstN    = 1'b0;
  logic        hsel    = 1'b0;
  logic [31:0] haddr   = 32'h0;
  logic [1:0]  htrans  = port_dir_pkg::HTRANS_IDLE;
  logic        hwrite  = 1'b0;
  logic [2:0]  hsize   = 3'h2;
  logic [31:0] hwdata  = 32'h0;
  logic        rdPhase = 1'b0;
  logic [31:0] seed    = 32'hb9750329;
  logic [7:0]  shadow [5];
  logic [31:0] hrdata;
  logic        hready;
  logic        hresp;
  logic [7:0]  port5Oe, port6Oe, port7Oe, port8Oe;
  logic [3:0]  portaOe;
  logic [31:0] d;
  note_s       notes [$];
  note_s       note;
  int          nFail       = 0;
  int          totalChecks = 0;

  always #4 mclk = ~mclk;

  port_direction_control port_direction_control_i (
    .mclk(mclk), .rst_n(rstN), .hsel(hsel), .haddr(haddr), .htrans(htrans),
    .hwrite(hwrite), .hsize(hsize), .hwdata(hwdata), .hready(hready),
    .hrdata(hrdata), .hreadyout(hready), .hresp(hresp), .port5Oe(port5Oe),
    .port6Oe(port6Oe), .port7Oe(port7Oe), .port8Oe(port8Oe), .portaOe(portaOe)
  );

  function automatic logic [31:0] xorshift(input logic [31:0] s);
    logic [31:0] x;
    x = s ^ (s << 13);
    x = x ^ (x >> 17);
    return x ^ (x << 5);
  endfunction

  // Single transfer; a read leaves its expected data and pin state in the queue
  task automatic xfer(input logic w, input logic [31:0] a, input logic [31:0] wd,
                      input logic [31:0] eRd);
    hsel   <= 1'b1;
    htrans <= port_dir_pkg::HTRANS_NSEQ;
    haddr  <= a;
    hwrite <= w;
    do @(posedge mclk); while (hready !== 1'b1);
    htrans  <= port_dir_pkg::HTRANS_IDLE;
    hwdata  <= wd;
    rdPhase <= !w;
    if (!w)
      notes.push_back('{eRd, {shadow[0], shadow[1], shadow[2], shadow[3], shadow[4][3:0]}});
    do @(posedge mclk); while (hready !== 1'b1);
    rdPhase <= 1'b0;
  endtask

  task automatic readAll();
    for (int i = 0; i < 5; i++)
      xfer(1'b0, {20'h0, REG_ADDR[i]}, 32'h0,
           (i == 4) ? {24'h0, shadow[4]} : port_dir_pkg::WO_READ_VAL);
  endtask

  task automatic doReset();
    rstN <= 1'b0;
    repeat (2) @(posedge mclk);
    rstN <= 1'b1;
    foreach (shadow[i]) shadow[i] = port_dir_pkg::RST_DIR;
    // Two-flop release plus one edge before the first address phase
    repeat (3) @(posedge mclk);
  endtask

  always @(posedge mclk)
    if (rdPhase && hready === 1'b1)
    begin
      note = notes.pop_front();
      `CHK("hrdata", note.rd, hrdata)
      `CHK("pins", note.oe, {port5Oe, port6Oe, port7Oe, port8Oe, portaOe})
      `CHK("hresp", 1'b0, hresp)
    end

  task automatic endOfTest();
    $display("checks %0d mismatches %0d", totalChecks, nFail);
    if (nFail == 0 && totalChecks > 0)
      $display("== PASSED ==");
    else
      $display("== FAILED ==");
    $finish;
  endtask

  initial
  begin
    foreach (shadow[i]) shadow[i] = 8'h00;
    doReset();
    readAll();
    // All ones first so every bit is driven high, then random patterns
    for (int r = 0; r < 8; r++)
      for (int i = 0; i < 5; i++)
      begin
        seed = xorshift(seed);
        d = (r == 0) ? 32'hffff_ffff : seed;
        // Upper address bits are not decoded, so randomising them must not matter
        xfer(1'b1, {seed[31:12], REG_ADDR[i]}, d, 32'h0);
        shadow[i] = (i == 4) ? {4'h0, d[3:0]} : d[7:0];
        xfer(1'b0, {20'h0, REG_ADDR[i]}, 32'h0,
             (i == 4) ? {28'h0, d[3:0]} : port_dir_pkg::WO_READ_VAL);
      end
    xfer(1'b1, 32'h0000_03b4, 32'hffff_ffff, 32'h0);
    xfer(1'b0, 32'h0000_03b4, 32'h0, 32'h0);
    readAll();
    doReset();
    readAll();
    @(posedge mclk);
    endOfTest();
  end

  initial
  begin
    #20000;
    nFail++;
    endOfTest();
  end
endmodule
